// ---- logic/twsm_master.sv ----
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
module twsm_master
    import twsm_pkg::*;
#(
    parameter int QTR_CYCLES = QTR_CYC
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire twsm_apb_req_t apb_req,
    output twsm_apb_rsp_t      apb_rsp,
    input  wire logic          sda_i,
    output logic               sda_o,
    output logic               sda_oe_n,
    input  wire logic          scl_i,
    output logic               scl_o,
    output logic               scl_oe_n
);

    twsm_regs_t q;
    twsm_regs_t d;

    logic        setup;
    logic        wr;
    logic        sda_s;
    logic        scl_s;
    logic        adv;
    logic        stretch;
    logic        out_bit;
    logic [15:0] reload;

    // Sensed pin levels come only from the second synchroniser stage
    assign sda_s   = q.sda_sync[1];
    assign scl_s   = q.scl_sync[1];
    assign setup   = apb_req.psel & ~apb_req.penable;
    assign wr      = apb_req.psel & apb_req.penable & q.rsp.pready & apb_req.pwrite;
    assign reload  = 16'(QTR_CYCLES - 1);
    // A slave holding the clock low freezes the quarter timer
    assign stretch = q.scl_lvl & ~scl_s;
    assign adv     = (q.fsm != TWSM_IDLE) & (q.timer == 16'h0000) & ~stretch;
    // Ack slot: receiver drives, transmitter releases
    assign out_bit = (q.bit_idx == ACK_IDX) ? (q.do_read ? q.nack_lvl : 1'b1)
                                            : (q.do_read ? 1'b1 : q.shift[7]);

    // Next-state logic for the whole block
    always_comb begin
        d = q;
        d.sda_sync = {q.sda_sync[0], sda_i};
        d.scl_sync = {q.scl_sync[0], scl_i};
        d.sda_prev = sda_s;
        d.scl_prev = scl_s;
        d.drv_low  = 1'b0;

        // Bus occupancy follows start and stop seen on the wires
        if (q.scl_prev && scl_s && q.sda_prev && !sda_s) begin
            d.bus_busy = 1'b1;
        end else if (q.scl_prev && scl_s && !q.sda_prev && sda_s) begin
            d.bus_busy = 1'b0;
        end

        // APB setup phase: decode and register the answer
        d.rsp.pready  = setup;
        d.rsp.pslverr = 1'b0;
        d.rsp.prdata  = 32'h0000_0000;
        if (setup && !apb_req.pwrite) begin
            case (apb_req.paddr)
                OFS_DATA_LINE: begin
                    d.rsp.prdata[LVL_OUT_BIT] = q.sda_lvl;
                    d.rsp.prdata[LVL_IN_BIT]  = sda_s;
                end
                OFS_CLOCK_LINE: begin
                    d.rsp.prdata[LVL_OUT_BIT] = q.scl_lvl;
                    d.rsp.prdata[LVL_IN_BIT]  = scl_s;
                end
                OFS_CMD: ;
                OFS_TX_DATA: d.rsp.prdata[7:0] = q.tx;
                OFS_RX_DATA: d.rsp.prdata[7:0] = q.rx;
                OFS_STATUS: begin
                    d.rsp.prdata[ST_BUSY_BIT] = (q.fsm != TWSM_IDLE);
                    d.rsp.prdata[ST_BUS_BIT]  = q.bus_busy;
                    d.rsp.prdata[ST_ACKN_BIT] = q.ack_n;
                    d.rsp.prdata[ST_DONE_BIT] = q.done;
                end
                default: d.rsp.pslverr = 1'b1;
            endcase
        end else if (setup) begin
            case (apb_req.paddr)
                OFS_DATA_LINE, OFS_CLOCK_LINE, OFS_CMD,
                OFS_TX_DATA, OFS_RX_DATA, OFS_STATUS: ;
                default: d.rsp.pslverr = 1'b1;
            endcase
        end

        // APB access edge: writes take effect here
        if (wr) begin
            case (apb_req.paddr)
                OFS_DATA_LINE: begin
                    // Manual levels only while the sequencer is idle
                    if (q.fsm == TWSM_IDLE) begin
                        d.sda_lvl = apb_req.pwdata[LVL_OUT_BIT];
                    end
                end
                OFS_CLOCK_LINE: begin
                    if (q.fsm == TWSM_IDLE) begin
                        d.scl_lvl = apb_req.pwdata[LVL_OUT_BIT];
                    end
                end
                OFS_TX_DATA: begin
                    // Software loads address byte, register byte or data here
                    if (q.fsm == TWSM_IDLE) begin
                        d.tx = apb_req.pwdata[7:0];
                    end
                end
                OFS_STATUS: begin
                    if (apb_req.pwdata[ST_DONE_BIT]) begin
                        d.done = 1'b0;
                    end
                end
                OFS_CMD: begin
                    if (q.fsm == TWSM_IDLE) begin
                        d.do_read  = apb_req.pwdata[CMD_READ_BIT];
                        d.do_xfer  = apb_req.pwdata[CMD_WRITE_BIT]
                                   | apb_req.pwdata[CMD_READ_BIT];
                        d.do_stop  = apb_req.pwdata[CMD_STOP_BIT];
                        d.nack_lvl = apb_req.pwdata[CMD_NACK_BIT];
                        d.timer    = reload;
                        d.step     = 3'h0;
                        d.bit_idx  = 4'h0;
                        d.shift    = q.tx;
                        if (apb_req.pwdata[CMD_START_BIT]) begin
                            d.fsm     = TWSM_START;
                            d.sda_lvl = 1'b1;
                        end else if (d.do_xfer) begin
                            d.fsm     = TWSM_XFER;
                            d.scl_lvl = 1'b0;
                        end else if (d.do_stop) begin
                            d.fsm     = TWSM_STOP;
                            d.scl_lvl = 1'b0;
                        end
                    end
                end
                default: ;
            endcase
        end

        // Quarter timer; held while a slave stretches the clock
        if (q.fsm != TWSM_IDLE) begin
            if (adv) begin
                d.timer = reload;
                d.step  = 3'(q.step + 3'h1);
            end else if (!stretch && q.timer != 16'h0000) begin
                d.timer = 16'(q.timer - 16'h0001);
            end
        end

        // Sequencer: levels change on entry to each quarter step
        if (adv) begin
            case (q.fsm)
                TWSM_START: begin
                    case (q.step)
                        3'h0: d.scl_lvl = 1'b1;
                        3'h1: d.sda_lvl = 1'b0;
                        default: ;
                    endcase
                    if (q.step == START_LAST) begin
                        d.step = 3'h0;
                        if (q.do_xfer) begin
                            d.fsm     = TWSM_XFER;
                            d.scl_lvl = 1'b0;
                        end else if (q.do_stop) begin
                            d.fsm     = TWSM_STOP;
                            d.scl_lvl = 1'b0;
                        end else begin
                            d.fsm  = TWSM_IDLE;
                            d.done = 1'b1;
                        end
                    end
                end
                TWSM_XFER: begin
                    case (q.step)
                        3'h0: d.sda_lvl = out_bit;
                        3'h1: d.scl_lvl = 1'b1;
                        default: ;
                    endcase
                    if (q.step == BIT_LAST) begin
                        // Sample at the end of the high phase, then drop clock
                        d.step    = 3'h0;
                        d.scl_lvl = 1'b0;
                        if (q.bit_idx == ACK_IDX) begin
                            d.ack_n = sda_s;
                            if (q.do_read) begin
                                d.rx = q.shift;
                            end
                            if (q.do_stop) begin
                                d.fsm = TWSM_STOP;
                            end else begin
                                d.fsm  = TWSM_IDLE;
                                d.done = 1'b1;
                            end
                        end else begin
                            d.shift   = {q.shift[6:0], sda_s};
                            d.bit_idx = 4'(q.bit_idx + 4'h1);
                        end
                    end
                end
                TWSM_STOP: begin
                    case (q.step)
                        3'h0: d.sda_lvl = 1'b0;
                        3'h1: d.scl_lvl = 1'b1;
                        3'h3: d.sda_lvl = 1'b1;
                        default: ;
                    endcase
                    if (q.step == STOP_LAST) begin
                        // Three idle quarters give the free time before a new start
                        d.step = 3'h0;
                        d.fsm  = TWSM_IDLE;
                        d.done = 1'b1;
                    end
                end
                default: d.fsm = TWSM_IDLE;
            endcase
        end

        // Open drain: enable low pulls the wire low, never drives high
        d.sda_oe_n = d.sda_lvl;
        d.scl_oe_n = d.scl_lvl;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q          <= '0;
            q.sda_sync <= {LINE_RST, LINE_RST};
            q.scl_sync <= {LINE_RST, LINE_RST};
            q.sda_prev <= LINE_RST;
            q.scl_prev <= LINE_RST;
            q.sda_lvl  <= LINE_RST;
            q.scl_lvl  <= LINE_RST;
            q.sda_oe_n <= LINE_RST;
            q.scl_oe_n <= LINE_RST;
            q.fsm      <= TWSM_IDLE;
            q.tx       <= BYTE_RST;
            q.rx       <= BYTE_RST;
            q.shift    <= BYTE_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign apb_rsp  = q.rsp;
    assign sda_o    = q.drv_low;
    assign scl_o    = q.drv_low;
    assign sda_oe_n = q.sda_oe_n;
    assign scl_oe_n = q.scl_oe_n;

endmodule // twsm_master

// ---- logic/twsm_pkg.sv ----
// Behaviour
// - This block alone makes start and stop
// - Data changes only while clock is low
// - Start: data falls while clock high
// - Stop: data rises while clock high
// - Bus busy from start until stop
// - Whole bytes, most significant bit first
// - Ninth clock carries the acknowledge bit
// - Clock never faster than 100 kbit/s
// - Lines only pulled low or released
// - Address byte: seven bits plus direction
// - Every transaction opens with start, address
// - Register address byte follows slave address
// - Master writes data; slave drives reads
// - Data-line write: bit 0 sets pin
// - Data-line read: bit 1 shows pin
// - Clock-line write: bit 0 sets pin
// - Clock-line read: bit 1 shows pin
package twsm_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_DATA_LINE  = 8'h00;
    localparam logic [7:0] OFS_CLOCK_LINE = 8'h04;
    localparam logic [7:0] OFS_CMD        = 8'h08;
    localparam logic [7:0] OFS_TX_DATA    = 8'h0c;
    localparam logic [7:0] OFS_RX_DATA    = 8'h10;
    localparam logic [7:0] OFS_STATUS     = 8'h14;

    // Field positions
    localparam int LVL_OUT_BIT   = 0;
    localparam int LVL_IN_BIT    = 1;
    localparam int CMD_START_BIT = 0;
    localparam int CMD_STOP_BIT  = 1;
    localparam int CMD_WRITE_BIT = 2;
    localparam int CMD_READ_BIT  = 3;
    localparam int CMD_NACK_BIT  = 4;
    localparam int ST_BUSY_BIT   = 0;
    localparam int ST_BUS_BIT    = 1;
    localparam int ST_ACKN_BIT   = 2;
    localparam int ST_DONE_BIT   = 3;

    // Reset values
    localparam logic       LINE_RST = 1'b1;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // Timing: quarter of the shortest legal bit period, rounded up
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCL_MAX_KHZ   = 100;
    localparam int SCL_PERIOD_NS = 1000000 / SCL_MAX_KHZ;
    localparam int QTR_CYC       = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

    // Last step index of each phase, and the ack bit index
    localparam logic [2:0] START_LAST = 3'h3;
    localparam logic [2:0] BIT_LAST   = 3'h3;
    localparam logic [2:0] STOP_LAST  = 3'h6;
    localparam logic [3:0] ACK_IDX    = 4'h8;

    typedef enum logic [1:0] {
        TWSM_IDLE,
        TWSM_START,
        TWSM_XFER,
        TWSM_STOP
    } twsm_fsm_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } twsm_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } twsm_apb_rsp_t;

    typedef struct packed {
        logic [1:0]    sda_sync;
        logic [1:0]    scl_sync;
        logic          sda_prev;
        logic          scl_prev;
        logic          sda_lvl;
        logic          scl_lvl;
        logic          drv_low;
        logic          sda_oe_n;
        logic          scl_oe_n;
        twsm_fsm_t     fsm;
        logic [2:0]    step;
        logic [3:0]    bit_idx;
        logic [15:0]   timer;
        logic          do_xfer;
        logic          do_read;
        logic          do_stop;
        logic          nack_lvl;
        logic [7:0]    shift;
        logic [7:0]    tx;
        logic [7:0]    rx;
        logic          ack_n;
        logic          done;
        logic          bus_busy;
        twsm_apb_rsp_t rsp;
    } twsm_regs_t;

endpackage

// ---- test/twsm_master_properties.sv ----
`timescale 1ns/100ps
module twsm_master_properties
    import twsm_pkg::*;
#(
    parameter int QTR_CYCLES = QTR_CYC
) (
    input wire logic          pclk,
    input wire logic          presetn,
    input wire twsm_apb_req_t apb_req,
    input wire twsm_apb_rsp_t apb_rsp,
    input wire logic          sda_i,
    input wire logic          sda_o,
    input wire logic          sda_oe_n,
    input wire logic          scl_i,
    input wire logic          scl_o,
    input wire logic          scl_oe_n
);
    logic [11:0] per_q;
    logic        map;

    // Cycles since the last clock release, saturating so idle gaps never wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_q <= 12'hfff;
        end else begin
            per_q <= $rose(scl_oe_n) ? 12'h001 : per_q + {11'h0, per_q != 12'hfff};
        end
    end
    // Aligned words up to the status register are mapped
    assign map = (apb_req.paddr[1:0] == 2'b00) && (apb_req.paddr <= OFS_STATUS);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ready_timing_a: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
        else $error("pready missing after setup");
    ready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready longer than one cycle");
    slverr_map_a: assert property (apb_rsp.pready |-> apb_rsp.pslverr == !map)
        else $error("pslverr does not match address map");
    open_drain_a: assert property (sda_o == 1'b0 && scl_o == 1'b0)
        else $error("line driven high");
    data_hold_a: assert property ($changed(scl_oe_n) |-> $stable(sda_oe_n))
        else $error("data moved with clock edge");
    bit_rate_a: assert property ($rose(scl_oe_n) |-> per_q >= 4 * QTR_CYCLES)
        else $error("clock period too short");
    start_hold_a: assert property ($fell(sda_oe_n) && scl_oe_n |-> scl_oe_n [*3])
        else $error("start not held");
    stop_hold_a: assert property ($rose(sda_oe_n) && scl_oe_n |=> (sda_oe_n && scl_oe_n) [*4])
        else $error("stop not held");

    cover property ($fell(sda_oe_n) && scl_oe_n);
    cover property ($rose(sda_oe_n) && scl_oe_n);
    cover property (apb_rsp.pready && apb_rsp.pslverr);
endmodule // twsm_master_properties

// ---- test/twsm_slave_model.sv ----
`timescale 1ns/100ps
module twsm_slave_model #(
    parameter logic [6:0] DEV_ADDR = 7'h2a
) (
    input  wire logic scl,
    input  wire logic sda,
    output logic      pull_n
);
    logic [7:0] mem [256];
    logic [7:0] sh;
    logic [7:0] tx;
    logic [7:0] ptr;
    int         cnt;
    int         nb;
    logic       act;
    logic       rd;
    logic       mack;

    initial begin
        pull_n = 1'b1;
        act = 1'b0;
        foreach (mem[i]) mem[i] = 8'h00;
    end
    // Start opens a frame; counters restart so a repeated start works too
    always @(negedge sda) if (scl) begin
        act = 1'b1;
        cnt = 0;
        nb = 0;
        rd = 1'b0;
    end
    // Stop frees the bus and the data wire
    always @(posedge sda) if (scl) begin
        act = 1'b0;
        pull_n = 1'b1;
    end
    // Sample on rising clock, most significant bit first; ninth bit is the ack
    always @(posedge scl) if (act) begin
        if (cnt < 8) sh = {sh[6:0], sda};
        else mack = ~sda;
        cnt++;
    end
    // Change the wire only after clock falls, and only by pulling or releasing
    always @(negedge scl) if (act) begin
        if (cnt == 8) begin
            if (nb == 0) begin
                act = (sh[7:1] == DEV_ADDR);
                rd = sh[0];
            end else if (!rd) begin
                if (nb == 1) ptr = sh;
                else begin
                    mem[ptr] = sh;
                    ptr++;
                end
            end
            pull_n = ~(act && (nb == 0 || !rd));
            nb++;
        end else if (cnt == 9) begin
            cnt = 0;
            if (rd && (nb == 1 || mack)) begin
                tx = mem[ptr];
                ptr++;
            end else tx = 8'hff;
            pull_n = tx[7];
        end else if (rd && nb > 0) pull_n = tx[7 - cnt];
    end
endmodule // twsm_slave_model

// ---- test/tb_two_wire_serial_master.sv ----
`timescale 1ns/100ps
module tb_two_wire_serial_master
    import twsm_pkg::*;
;
    localparam logic [6:0] DEV = 7'h2a;
    logic          pclk;
    logic          presetn;
    twsm_apb_req_t req;
    twsm_apb_rsp_t rsp;
    logic          sda_oe_n;
    logic          scl_oe_n;
    logic          pull_n;
    wire           sda_w = sda_oe_n & pull_n;
    int            fails;
    int            n_checks;
    int            cyc;
    logic [31:0]   rd;
    logic [31:0]   v;
    logic [7:0]    r;
    logic [7:0]    d0;
    logic [7:0]    d1;
    logic          err;

    twsm_master #(.QTR_CYCLES(4)) uut (.pclk(pclk), .presetn(presetn), .apb_req(req),
        .apb_rsp(rsp), .sda_i(sda_w), .sda_o(), .sda_oe_n(sda_oe_n), .scl_i(scl_oe_n),
        .scl_o(), .scl_oe_n(scl_oe_n));
    twsm_slave_model #(.DEV_ADDR(DEV)) u_slv (.scl(scl_oe_n), .sda(sda_w), .pull_n(pull_n));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Watchdog: a hang is counted and closes the run
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            fails++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks=%0d errors=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Expected status {ack level, bus busy, sequencer busy} once done has been seen
    function automatic logic [2:0] stat_exp(input logic ackn, input logic bus);
        return {ackn, bus, 1'b0};
    endfunction
    // One APB transfer; waits an edge first so the bus is never reassigned in one step
    // No local limit on the wait: only the watchdog may end a hung transfer
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        req <= '{1'b1, 1'b0, wr, a, wd};
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask
    // Send a command, poll done, clear it; status lands in v
    task automatic cmd(input logic [7:0] c, input logic [7:0] tx);
        apb(1'b1, OFS_TX_DATA, {24'h0, tx});
        apb(1'b1, OFS_CMD, {24'h0, c});
        do begin
            apb(1'b0, OFS_STATUS, 32'h0);
        end while (rd[ST_DONE_BIT] !== 1'b1);
        v = rd;
        apb(1'b1, OFS_STATUS, 32'h8);
    endtask
    // Long wait keeps manual clock toggles inside the legal rate
    task automatic line(input logic [7:0] a, input logic lvl);
        v = $urandom;
        v[0] = lvl;
        apb(1'b1, a, v);
        repeat (20) @(posedge pclk);
        chk({31'h0, a == OFS_DATA_LINE ? sda_oe_n : scl_oe_n}, {31'h0, lvl});
        apb(1'b0, a, 32'h0);
        chk(rd, {30'h0, lvl, lvl});
    endtask

    initial begin
        req = '0;
        presetn = 1'b0;
        fails = 0;
        n_checks = 0;
        cyc = 0;
        v = $urandom(32'hb893);
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) line(OFS_DATA_LINE, i[0]);
        for (int i = 0; i < 6; i++) line(OFS_CLOCK_LINE, i[0]);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        r = $urandom;
        d0 = $urandom;
        d1 = $urandom;
        cmd(8'h05, {DEV, 1'b0});
        chk(v[2:0], stat_exp(1'b0, 1'b1));
        cmd(8'h04, r);
        cmd(8'h04, d0);
        cmd(8'h06, d1);
        chk(v[2:0], stat_exp(1'b0, 1'b0));
        chk({u_slv.mem[r], u_slv.mem[r + 8'h1]}, {d0, d1});
        cmd(8'h05, {DEV, 1'b0});
        cmd(8'h04, r);
        cmd(8'h05, {DEV, 1'b1});
        cmd(8'h08, 8'h0);
        apb(1'b0, OFS_RX_DATA, 32'h0);
        chk(rd, {24'h0, d0});
        cmd(8'h1a, 8'h0);
        apb(1'b0, OFS_RX_DATA, 32'h0);
        chk(rd, {24'h0, d1});
        cmd(8'h07, {DEV ^ 7'h1, 1'b0});
        chk({31'h0, v[ST_ACKN_BIT]}, 32'h1);
        end_of_test();
    end
endmodule // tb_two_wire_serial_master

bind twsm_master twsm_master_properties #(.QTR_CYCLES(QTR_CYCLES)) u_props (.pclk(pclk),
    .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_n(scl_oe_n));
